// file: src/unprot_pkg.sv
// constants shared by the block unprotect sequencer
package unprot_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_PROT_LO = 8'h08;
  localparam logic [7:0] OFF_PROT_HI = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  // command word fields
  localparam int CMD_CODE_LSB = 0;
  localparam int BLK_LSB = 8;
  localparam int BLK_W = 6;
  // command codes
  localparam logic [7:0] CMD_SETUP = 8'h60;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_CLEAR = 8'h50;
  // status bit positions
  localparam int ST_ENABLE_INV = 3;
  localparam int ST_PROG_ERR = 4;
  localparam int ST_ERASE_ERR = 5;
  localparam int ST_READY = 7;
  localparam int ST_ARRAY_MODE = 8;
  // interrupt bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  // reset values
  localparam logic [63:0] PROT_RESET = 64'hFFFFFFFFFFFFFFFF;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int UNPROT_TIME_NS = 20000;
  localparam int UNPROT_CYCLES =
    (UNPROT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] UNPROT_LAST = CNT_W'(UNPROT_CYCLES - 1);
  // sequencer states
  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_BUSY} seq_state_t;
endpackage : unprot_pkg

// file: src/flash_block_unprotect_sequence.sv
// flash block unprotect command sequencer with ahb-lite registers
// What this block does
// RULE1: unprotect starts on setup 60h then confirm D0h, same block address
// RULE2: ready bit reads 0 while busy, 1 once the unprotect completes
// RULE3: enable level invalid at confirm sets enable_invalid_bit, nothing runs
// RULE4: bad sequence sets program_error_bit and erase_error_bit together
// RULE5: enable lost during operation sets erase_error_bit alone: failure
// RULE6: host writes FFh to return to array read mode
// RULE7: error bits stay set until the clear status command
// RULE8: blocks unprotected only when no enable, sequence or failure error
//
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module flash_block_unprotect_sequence
  import unprot_pkg::*;
(
  input wire logic CLK,            // system clock, 25 mhz
  input wire logic RST,            // synchronous reset, active high
  input wire logic HSEL,           // slave select
  input wire logic [7:0] HADDR,    // byte address
  input wire logic [1:0] HTRANS,   // transfer type
  input wire logic HWRITE,         // write when high
  input wire logic [2:0] HSIZE,    // transfer size, word only
  input wire logic [31:0] HWDATA,  // write data
  input wire logic HREADY,         // bus ready in
  output logic [31:0] HRDATA,      // read data, registered
  output logic HREADYOUT,          // always ready
  output logic HRESP,              // always okay
  input wire logic PROG_ERASE_EN,  // program_erase_enable_input pin
  output logic IRQ                 // level interrupt
);

  // address decode helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction : hit

  // enable pin comes from outside, two flops before use
  logic pen_m_q, pen_q;
  always_ff @(posedge CLK) begin
    if (RST) begin
      pen_m_q <= 1'b0;
      pen_q <= 1'b0;
    end else begin
      pen_m_q <= PROG_ERASE_EN;
      pen_q <= pen_m_q;
    end
  end

  // ahb address phase capture
  logic wr_q, wr_d, rd_d;
  logic [7:0] addr_q, addr_d;
  always_comb begin
    wr_d = HSEL && HTRANS[1] && HREADY && HWRITE;
    rd_d = HSEL && HTRANS[1] && HREADY && !HWRITE;
    addr_d = wr_d ? HADDR : addr_q;
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q <= wr_d;
      addr_q <= addr_d;
    end
  end

  // write strobes of the data phase
  logic cmd_we, istat_we, imask_we;
  logic [7:0] code;
  logic [BLK_W-1:0] blk;
  assign cmd_we = wr_q && hit(addr_q, OFF_CMD);
  assign istat_we = wr_q && hit(addr_q, OFF_IRQ_STAT);
  assign imask_we = wr_q && hit(addr_q, OFF_IRQ_MASK);
  assign code = HWDATA[CMD_CODE_LSB +: 8];
  assign blk = HWDATA[BLK_LSB +: BLK_W];

  // sequencer state
  seq_state_t state_q, state_d;
  logic [BLK_W-1:0] blk_q, blk_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic lost_q, lost_d;
  logic array_q, array_d;
  logic einv_q, einv_d, perr_q, perr_d, eerr_q, eerr_d;
  logic [63:0] prot_q, prot_d;
  logic ev_done, ev_err;

  // next state of sequencer and status; a set beats a clear
  always_comb begin
    logic set_einv, set_perr, set_eerr, clr;
    set_einv = 1'b0;
    set_perr = 1'b0;
    set_eerr = 1'b0;
    clr = 1'b0;
    state_d = state_q;
    blk_d = blk_q;
    cnt_d = cnt_q;
    lost_d = lost_q;
    array_d = array_q;
    prot_d = prot_q;
    ev_done = 1'b0;
    case (state_q)
      S_IDLE: begin
        if (cmd_we) begin
          case (code)
            CMD_SETUP: begin // [RULE1]
              state_d = S_SETUP;
              blk_d = blk;
              array_d = 1'b0;
            end
            CMD_CLEAR: begin // [RULE7]
              clr = 1'b1;
              array_d = 1'b0;
            end
            CMD_ARRAY: array_d = 1'b1; // [RULE6]
            default: ;
          endcase
        end
      end
      S_SETUP: begin
        if (cmd_we) begin
          state_d = S_IDLE;
          if (code == CMD_CONFIRM && blk == blk_q) begin // [RULE1]
            if (!pen_q) begin
              set_einv = 1'b1; // [RULE3]
            end else begin
              state_d = S_BUSY; // [RULE2]
              cnt_d = '0;
              lost_d = 1'b0;
            end
          end else begin
            set_perr = 1'b1; // [RULE4]
            set_eerr = 1'b1; // [RULE4]
          end
        end
      end
      S_BUSY: begin
        // commands are ignored while the operation runs
        cnt_d = cnt_q + 1'b1;
        if (!pen_q) lost_d = 1'b1;
        if (cnt_q == UNPROT_LAST) begin
          state_d = S_IDLE; // [RULE2]
          ev_done = 1'b1;
          if (lost_d) set_eerr = 1'b1; // [RULE5]
          else prot_d = '0; // [RULE8]
        end
      end
      default: state_d = S_IDLE;
    endcase
    einv_d = set_einv | (einv_q & ~clr); // [RULE7]
    perr_d = set_perr | (perr_q & ~clr);
    eerr_d = set_eerr | (eerr_q & ~clr);
    ev_err = set_einv | set_perr | set_eerr;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= S_IDLE;
      blk_q <= '0;
      cnt_q <= '0;
      lost_q <= 1'b0;
      array_q <= 1'b1;
      einv_q <= 1'b0;
      perr_q <= 1'b0;
      eerr_q <= 1'b0;
      prot_q <= PROT_RESET;
    end else begin
      state_q <= state_d;
      blk_q <= blk_d;
      cnt_q <= cnt_d;
      lost_q <= lost_d;
      array_q <= array_d;
      einv_q <= einv_d;
      perr_q <= perr_d;
      eerr_q <= eerr_d;
      prot_q <= prot_d;
    end
  end

  // interrupt status, write one to clear, event wins over clear
  logic [1:0] ist_q, ist_d, imsk_q, imsk_d;
  always_comb begin
    ist_d = ist_q & ~(istat_we ? HWDATA[1:0] : 2'h0);
    ist_d[IRQ_DONE] = ist_d[IRQ_DONE] | ev_done;
    ist_d[IRQ_ERR] = ist_d[IRQ_ERR] | ev_err;
    imsk_d = imask_we ? HWDATA[1:0] : imsk_q;
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      ist_q <= 2'h0;
      imsk_q <= IRQ_MASK_RESET;
    end else begin
      ist_q <= ist_d;
      imsk_q <= imsk_d;
    end
  end
  assign IRQ = |(ist_q & imsk_q);

  // read data, latched in the address phase so zero wait states hold;
  // a write in the previous data phase may not be reflected yet
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] status_w;
  always_comb begin
    status_w = 32'h0;
    status_w[ST_READY] = (state_q != S_BUSY); // [RULE2]
    status_w[ST_ENABLE_INV] = einv_q;
    status_w[ST_PROG_ERR] = perr_q;
    status_w[ST_ERASE_ERR] = eerr_q;
    status_w[ST_ARRAY_MODE] = array_q;
    rdata_d = 32'h0;
    if (rd_d) begin
      if (hit(HADDR, OFF_STATUS)) rdata_d = status_w;
      else if (hit(HADDR, OFF_PROT_LO)) rdata_d = prot_q[31:0];
      else if (hit(HADDR, OFF_PROT_HI)) rdata_d = prot_q[63:32];
      else if (hit(HADDR, OFF_IRQ_STAT)) rdata_d = {30'h0, ist_q};
      else if (hit(HADDR, OFF_IRQ_MASK)) rdata_d = {30'h0, imsk_q};
      else rdata_d = 32'h0;
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) rdata_q <= 32'h0;
    else rdata_q <= rdata_d;
  end
  assign HRDATA = rdata_q;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // checks
  localparam int BUSY_MAX = 510;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_confirm;
    state_q == S_SETUP && cmd_we && code == CMD_CONFIRM && blk == blk_q
      && pen_q |=> state_q == S_BUSY && !status_w[ST_READY];
  endproperty
  a_confirm: assert property (p_confirm) // [RULE1]
    else $error("confirm did not start unprotect");

  property p_ready;
    $fell(status_w[ST_READY]) |-> ##[1:BUSY_MAX] status_w[ST_READY];
  endproperty
  a_ready: assert property (p_ready) // [RULE2]
    else $error("ready bit never returned");

  // the busy time runs to its end, no command can cut it short
  property p_busy;
    state_q == S_BUSY && cnt_q != UNPROT_LAST
      |=> state_q == S_BUSY && !status_w[ST_READY];
  endproperty
  a_busy: assert property (p_busy) // [RULE2]
    else $error("busy time ended early");

  property p_pen;
    state_q == S_SETUP && cmd_we && code == CMD_CONFIRM && blk == blk_q
      && !pen_q |=> einv_q && state_q == S_IDLE && ist_q[IRQ_ERR];
  endproperty
  a_pen: assert property (p_pen) // [RULE3]
    else $error("invalid enable not reported");

  property p_seq;
    state_q == S_SETUP && cmd_we && code != CMD_CONFIRM
      |=> perr_q && eerr_q && state_q == S_IDLE;
  endproperty
  a_seq: assert property (p_seq) // [RULE4]
    else $error("sequence error not reported");

  property p_fail;
    state_q == S_BUSY && !pen_q
      |-> ##[1:BUSY_MAX] eerr_q && status_w[ST_READY];
  endproperty
  a_fail: assert property (p_fail) // [RULE5]
    else $error("lost enable did not fail unprotect");

  // a failed unprotect leaves the protect bits as they were
  property p_keep;
    state_q == S_BUSY && cnt_q == UNPROT_LAST && (lost_q || !pen_q)
      |=> $stable(prot_q) && eerr_q;
  endproperty
  a_keep: assert property (p_keep) // [RULE5]
    else $error("failed unprotect changed protection");

  property p_array;
    state_q == S_IDLE && cmd_we && code == CMD_ARRAY |=> array_q;
  endproperty
  a_array: assert property (p_array) // [RULE6]
    else $error("array read mode not entered");

  property p_sticky;
    eerr_q && !(state_q == S_IDLE && cmd_we && code == CMD_CLEAR)
      |=> eerr_q;
  endproperty
  a_sticky: assert property (p_sticky) // [RULE7]
    else $error("error bit dropped without clear");

  // clear status in idle drops all three error bits
  property p_clear;
    state_q == S_IDLE && cmd_we && code == CMD_CLEAR
      |=> !einv_q && !perr_q && !eerr_q;
  endproperty
  a_clear: assert property (p_clear) // [RULE7]
    else $error("clear status left an error bit set");

  property p_success;
    state_q == S_BUSY && cnt_q == UNPROT_LAST && !lost_q && pen_q
      |=> prot_q == 64'h0 && status_w[ST_READY] && $stable(eerr_q);
  endproperty
  a_success: assert property (p_success) // [RULE8]
    else $error("successful unprotect left blocks protected");

endmodule : flash_block_unprotect_sequence
`default_nettype wire

// file: bench/host_bus_model.sv
// ahb-lite host model issuing unprotect command sequences
`timescale 1ns/1ns
`default_nettype none
module host_bus_model
  import unprot_pkg::*;
(
  input wire logic CLK, // bus clock
  input wire logic HREADY, // bus ready
  input wire logic [31:0] HRDATA, // read data
  output logic HSEL, // select
  output logic [7:0] HADDR, // address
  output logic [1:0] HTRANS, // transfer type
  output logic HWRITE, // write
  output logic [2:0] HSIZE, // size, word
  output logic [31:0] HWDATA // write data
);
  initial begin
    HSEL = 1'b0;
    HADDR = 8'h00;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
  end
  // address phase, held until hready is seen high
  task automatic addr(input logic [7:0] a, input logic w);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= a;
    do @(posedge CLK); while (HREADY !== 1'b1);
    HTRANS <= 2'h0;
  endtask : addr
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr(a, 1'b1);
    HWDATA <= d;
    do @(posedge CLK); while (HREADY !== 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr(a, 1'b0);
    HWDATA <= ~HWDATA; // unused data lines keep changing
    do @(posedge CLK); while (HREADY !== 1'b1);
    d = HRDATA; // taken at the edge that ends the data phase
  endtask : rd
  task automatic cmd(input logic [7:0] c, input logic [5:0] b);
    wr(OFF_CMD, {18'h0, b, c});
  endtask : cmd
  // setup then second code, each with its own block number
  task automatic unprot(input logic [5:0] b1, b2, input logic [7:0] c);
    cmd(CMD_SETUP, b1);
    cmd(c, b2);
  endtask : unprot
  // error bits must go before any new operation
  task automatic clear();
    cmd(CMD_CLEAR, 6'h00);
  endtask : clear
  task automatic array();
    cmd(CMD_ARRAY, 6'h00);
  endtask : array
endmodule : host_bus_model
`default_nettype wire

// file: bench/flash_block_unprotect_sequence_tb_top.sv
// self-checking bench for the block unprotect sequencer
`timescale 1ns/1ns
`default_nettype none
module flash_block_unprotect_sequence_tb_top;
  import unprot_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b1;
  logic hsel, hwrite, hready, hresp, irq;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, v;
  int bad_count = 0;
  int tests_run = 0;
  always #20 clk = ~clk;
  flash_block_unprotect_sequence flash_block_unprotect_sequence_inst (
    .CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .PROG_ERASE_EN(en), .IRQ(irq));
  host_bus_model host_bus_model_inst (
    .CLK(clk), .HREADY(hready), .HRDATA(hrdata), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata));
  task automatic chk(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rchk(input string n, input logic [7:0] a,
                      input logic [31:0] e);
    host_bus_model_inst.rd(a, v);
    chk(n, v, e);
  endtask : rchk
  // let the edge's updates land before looking at the level
  task automatic ichk(input logic e);
    #1 chk("irq", {31'h0, irq}, {31'h0, e});
  endtask : ichk
  // bounded status polling, a hang shows as a wrong status later
  task automatic poll();
    int i;
    i = 0;
    do begin
      host_bus_model_inst.rd(OFF_STATUS, v);
      i++;
    end while (v[ST_READY] !== 1'b1 && i < 400);
  endtask : poll
  task automatic t_reset();
    rchk("status", OFF_STATUS, 32'h180);
    rchk("prot_lo", OFF_PROT_LO, 32'hFFFFFFFF);
    rchk("prot_hi", OFF_PROT_HI, 32'hFFFFFFFF);
    rchk("mask", OFF_IRQ_MASK, 32'h0);
    rchk("unmapped", 8'h18, 32'h0);
    ichk(1'b0);
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask : t_reset
  task automatic t_enable();
    @(posedge clk);
    en <= 1'b0;
    repeat (3) @(posedge clk);
    host_bus_model_inst.unprot(6'h05, 6'h05, CMD_CONFIRM);
    rchk("status", OFF_STATUS, 32'h088);
    rchk("prot_lo", OFF_PROT_LO, 32'hFFFFFFFF);
    rchk("irq_stat", OFF_IRQ_STAT, 32'h2);
    ichk(1'b0);
    host_bus_model_inst.wr(OFF_IRQ_MASK, 32'h3);
    ichk(1'b1);
    host_bus_model_inst.wr(OFF_IRQ_STAT, 32'h2);
    ichk(1'b0);
    rchk("status", OFF_STATUS, 32'h088);
    en <= 1'b1;
    host_bus_model_inst.clear();
    rchk("status", OFF_STATUS, 32'h080);
  endtask : t_enable
  task automatic t_sequence();
    host_bus_model_inst.cmd(8'h20, 6'h01);
    rchk("status", OFF_STATUS, 32'h080);
    host_bus_model_inst.unprot(6'h01, 6'h01, 8'h20);
    rchk("status", OFF_STATUS, 32'h0B0);
    ichk(1'b1);
    host_bus_model_inst.clear();
    host_bus_model_inst.unprot(6'h01, 6'h02, CMD_CONFIRM);
    rchk("status", OFF_STATUS, 32'h0B0);
    host_bus_model_inst.clear();
    host_bus_model_inst.wr(OFF_IRQ_STAT, 32'h3);
    rchk("prot_lo", OFF_PROT_LO, 32'hFFFFFFFF);
  endtask : t_sequence
  // enable lost part way through the busy time
  task automatic t_fail();
    host_bus_model_inst.unprot(6'h03, 6'h03, CMD_CONFIRM);
    repeat (20) @(posedge clk);
    en <= 1'b0;
    poll();
    en <= 1'b1;
    rchk("status", OFF_STATUS, 32'h0A0);
    rchk("prot_hi", OFF_PROT_HI, 32'hFFFFFFFF);
    host_bus_model_inst.clear();
    host_bus_model_inst.wr(OFF_IRQ_STAT, 32'h3);
    repeat (3) @(posedge clk);
  endtask : t_fail
  task automatic t_ok();
    host_bus_model_inst.unprot(6'h07, 6'h07, CMD_CONFIRM);
    rchk("busy", OFF_STATUS, 32'h000);
    poll();
    rchk("status", OFF_STATUS, 32'h080);
    rchk("prot_lo", OFF_PROT_LO, 32'h0);
    rchk("prot_hi", OFF_PROT_HI, 32'h0);
    rchk("irq_stat", OFF_IRQ_STAT, 32'h1);
    ichk(1'b1);
    host_bus_model_inst.array();
    rchk("status", OFF_STATUS, 32'h180);
  endtask : t_ok
  task automatic tally_and_finish();
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  // generous bound on the whole sequence of tests
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_enable();
    t_sequence();
    t_fail();
    t_ok();
    tally_and_finish();
  end
endmodule : flash_block_unprotect_sequence_tb_top
`default_nettype wire
